/* File: verilog/rotor_guard_defines.svh */
// Constants for the rotor position finder and bus overvoltage guard
`ifndef ROTOR_GUARD_DEFINES_SVH
`define ROTOR_GUARD_DEFINES_SVH
`define CLK_MHZ          125
`define PULSE_TIME_US    50
`define PULSE_CYCLES     ((`PULSE_TIME_US * `CLK_MHZ))
`define GAP_TIME_US      20
`define GAP_CYCLES       ((`GAP_TIME_US * `CLK_MHZ))
`define SETTLE_CYCLES    3
`define TMR_W            14
`define ADC_W            12
`define PHASES           3
`define PHASE_IDX_W      2
`define SECTOR_W         3
`define SECTOR_NONE      3'h0
`define ALL_OFF          3'h0
`define ALL_ON           3'h7
`endif

/* File: verilog/rotor_guard_pkg.sv */
// Types shared by the rotor position finder and bus overvoltage guard
package rotor_guard_pkg;
	typedef enum logic [4:0]
	{
		ST_IDLE  = 5'h01,
		ST_FWD   = 5'h02,
		ST_GAP   = 5'h04,
		ST_REV   = 5'h08,
		ST_DONE  = 5'h10
	} sense_state_t;
endpackage

/* File: verilog/peak_hold.sv */
// Peak detector for one phase current sample stream
`timescale 1ns/1ps
`include "rotor_guard_defines.svh"
module peak_hold
(
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic                  clear,
	input  wire logic                  sample_en,
	input  wire logic [`ADC_W-1:0]     sample,
	output logic      [`ADC_W-1:0]     peak_q
);
	always_ff @(posedge sys_clk)
	begin
		if (srst || clear)
			peak_q <= '0;
		else if (sample_en && sample > peak_q)
			peak_q <= sample;
	end
endmodule

/* File: verilog/rotor_position_and_bus_ov_guard.sv */
// Initial rotor position sensing and critical bus overvoltage guard
`timescale 1ns/1ps
`include "rotor_guard_defines.svh"
// Summary of operation
// - Each test pattern is applied for a fixed pulse time count.
// - Forward pulse: selected phase high, other two phases low.
// - Opposing pulse: other two phases high, selected phase low.
// - Peaks of both pulses compared; larger peak gives polarity bit.
// - Pulse pair repeated for all three phases; bits combine to sector.
// - Overvoltage flagged whenever bus voltage exceeds configured level.
// - Overvoltage forces zero vector at once, over every other condition.
// - Zero vector held until overvoltage fault is cleared.
module rotor_position_and_bus_ov_guard
	import rotor_guard_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic                  sense_start,
	input  wire logic [`ADC_W-1:0]     phase_current,
	input  wire logic                  current_valid,
	input  wire logic [`ADC_W-1:0]     bus_voltage,
	input  wire logic [`ADC_W-1:0]     ov_level,
	input  wire logic                  ov_clear,
	input  wire logic [`PHASES-1:0]    pwm_high_in,
	input  wire logic [`PHASES-1:0]    pwm_low_in,
	input  wire logic                  fault_active,
	output logic      [`PHASES-1:0]    gate_high_q,
	output logic      [`PHASES-1:0]    gate_low_q,
	output logic                       overvoltage_condition_q,
	output logic      [`SECTOR_W-1:0]  sector_q,
	output logic                       sector_done_q,
	output logic                       sensing_q
);
	import rotor_guard_pkg::*;

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [`PHASES-1:0] phase_mask
	(
		input logic [`PHASE_IDX_W-1:0] idx
	);
		phase_mask = `PHASES'(1) << idx;
	endfunction

	function automatic logic [`SECTOR_W-1:0] polarity_to_sector
	(
		input logic [`PHASES-1:0] pol
	);
		unique case (pol)
			3'h1:    polarity_to_sector = 3'h1;
			3'h3:    polarity_to_sector = 3'h2;
			3'h2:    polarity_to_sector = 3'h3;
			3'h6:    polarity_to_sector = 3'h4;
			3'h4:    polarity_to_sector = 3'h5;
			3'h5:    polarity_to_sector = 3'h6;
			default: polarity_to_sector = `SECTOR_NONE;
		endcase
	endfunction

	// ************************************************************
	// Inputs from outside the clock domain
	// ************************************************************
	logic                  start_s1_q;
	logic                  start_s2_q;
	logic                  start_s3_q;
	logic [`ADC_W-1:0]     cur_s1_q;
	logic [`ADC_W-1:0]     cur_s2_q;
	logic                  cval_s1_q;
	logic                  cval_s2_q;
	logic [`ADC_W-1:0]     vbus_s1_q;
	logic [`ADC_W-1:0]     vbus_s2_q;
	logic                  clr_s1_q;
	logic                  clr_s2_q;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			start_s1_q <= 1'b0;
			start_s2_q <= 1'b0;
			start_s3_q <= 1'b0;
			cur_s1_q   <= '0;
			cur_s2_q   <= '0;
			cval_s1_q  <= 1'b0;
			cval_s2_q  <= 1'b0;
			vbus_s1_q  <= '0;
			vbus_s2_q  <= '0;
			clr_s1_q   <= 1'b0;
			clr_s2_q   <= 1'b0;
		end
		else
		begin
			start_s1_q <= sense_start;
			start_s2_q <= start_s1_q;
			start_s3_q <= start_s2_q;
			cur_s1_q   <= phase_current;
			cur_s2_q   <= cur_s1_q;
			cval_s1_q  <= current_valid;
			cval_s2_q  <= cval_s1_q;
			vbus_s1_q  <= bus_voltage;
			vbus_s2_q  <= vbus_s1_q;
			clr_s1_q   <= ov_clear;
			clr_s2_q   <= clr_s1_q;
		end
	end

	logic start_pulse;
	assign start_pulse = start_s2_q && !start_s3_q;

	// ************************************************************
	// Bus overvoltage guard
	// ************************************************************
	logic ov_detect;
	assign ov_detect = vbus_s2_q > ov_level;

	// Detection wins over a clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			overvoltage_condition_q <= 1'b0;
		else if (ov_detect)
			overvoltage_condition_q <= 1'b1;
		else if (clr_s2_q)
			overvoltage_condition_q <= 1'b0;
	end

	logic guard_d;
	assign guard_d = ov_detect || overvoltage_condition_q;

	// ************************************************************
	// Rotor position sensing sequencer
	// ************************************************************
	sense_state_t                state_q;
	logic [`TMR_W-1:0]           tmr_q;
	logic [`PHASE_IDX_W-1:0]     phase_q;
	logic [`PHASES-1:0]          pol_q;
	logic [`ADC_W-1:0]           fwd_peak_q;
	logic [`ADC_W-1:0]           peak;
	logic                        peak_clear;
	logic                        tmr_end;
	logic                        last_phase;
	logic                        sample_win;
	logic                        start_take;

	assign tmr_end    = (tmr_q == '0);
	assign last_phase = (phase_q == `PHASE_IDX_W'(`PHASES - 1));
	assign peak_clear = (state_q == ST_GAP) || (state_q == ST_IDLE)
		|| (state_q == ST_DONE) || (state_q == ST_REV && tmr_end);
	// Skip samples that still lag from the previous pattern
	assign sample_win = tmr_q < `TMR_W'(`PULSE_CYCLES - `SETTLE_CYCLES);
	assign start_take = start_pulse && !guard_d
		&& (state_q == ST_IDLE || state_q == ST_DONE);

	peak_hold u_peak
	(
		.sys_clk   (sys_clk),
		.srst      (srst),
		.clear     (peak_clear),
		.sample_en (cval_s2_q && sample_win
			&& (state_q == ST_FWD || state_q == ST_REV)),
		.sample    (cur_s2_q),
		.peak_q    (peak)
	);

	always_ff @(posedge sys_clk)
	begin
		if (srst || guard_d)
		begin
			state_q <= ST_IDLE;
			tmr_q   <= '0;
			phase_q <= '0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE, ST_DONE:
					if (start_pulse)
					begin
						state_q <= ST_FWD;
						tmr_q   <= `TMR_W'(`PULSE_CYCLES - 1);
						phase_q <= '0;
					end
				ST_FWD:
					if (tmr_end)
					begin
						state_q <= ST_GAP;
						tmr_q   <= `TMR_W'(`GAP_CYCLES - 1);
					end
					else
						tmr_q <= tmr_q - `TMR_W'(1);
				ST_GAP:
					if (tmr_end)
					begin
						state_q <= ST_REV;
						tmr_q   <= `TMR_W'(`PULSE_CYCLES - 1);
					end
					else
						tmr_q <= tmr_q - `TMR_W'(1);
				ST_REV:
					if (!tmr_end)
						tmr_q <= tmr_q - `TMR_W'(1);
					else if (last_phase)
						state_q <= ST_DONE;
					else
					begin
						state_q <= ST_FWD;
						phase_q <= phase_q + `PHASE_IDX_W'(1);
						tmr_q   <= `TMR_W'(`PULSE_CYCLES - 1);
					end
			endcase
		end
	end

	// Forward peak kept for the comparison at the end of the pair
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			fwd_peak_q <= '0;
		else if (state_q == ST_FWD && tmr_end)
			fwd_peak_q <= peak;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || start_take)
			pol_q <= '0;
		else if (state_q == ST_REV && tmr_end)
			pol_q[phase_q] <= (fwd_peak_q > peak);
	end

	logic [`PHASES-1:0] pol_final;
	always_comb
	begin
		pol_final          = pol_q;
		pol_final[phase_q] = (fwd_peak_q > peak);
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || start_take)
		begin
			sector_q      <= `SECTOR_NONE;
			sector_done_q <= 1'b0;
		end
		else if (state_q == ST_REV && tmr_end && last_phase && !guard_d)
		begin
			sector_q      <= polarity_to_sector(pol_final);
			sector_done_q <= 1'b1;
		end
	end

	// ************************************************************
	// Gate outputs
	// ************************************************************
	logic [`PHASES-1:0] high_d;
	logic [`PHASES-1:0] low_d;
	always_comb
	begin
		high_d = pwm_high_in & ~pwm_low_in;
		low_d  = pwm_low_in;
		if (fault_active)
		begin
			high_d = `ALL_OFF;
			low_d  = `ALL_OFF;
		end
		unique case (state_q)
			ST_FWD:
			begin
				high_d = phase_mask(phase_q);
				low_d  = ~phase_mask(phase_q);
			end
			ST_REV:
			begin
				high_d = ~phase_mask(phase_q);
				low_d  = phase_mask(phase_q);
			end
			ST_GAP:
			begin
				high_d = `ALL_OFF;
				low_d  = `ALL_OFF;
			end
			ST_IDLE, ST_DONE:
			begin
			end
		endcase
		if (guard_d)
		begin
			high_d = `ALL_OFF;
			low_d  = `ALL_ON;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			gate_high_q <= `ALL_OFF;
			gate_low_q  <= `ALL_OFF;
			sensing_q   <= 1'b0;
		end
		else
		begin
			gate_high_q <= high_d;
			gate_low_q  <= low_d;
			sensing_q   <= (state_q == ST_FWD) || (state_q == ST_GAP)
				|| (state_q == ST_REV);
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	a_fwd_pattern: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_FWD && !guard_d |=> gate_high_q == phase_mask($past(phase_q))
			&& gate_low_q == ~gate_high_q)
		else $error("forward pattern wrong");
	a_rev_pattern: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_REV && !guard_d |=> gate_low_q == phase_mask($past(phase_q))
			&& gate_high_q == ~gate_low_q)
		else $error("opposing pattern wrong");
	a_pulse_length: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(state_q == ST_FWD) |-> tmr_q == `TMR_W'(`PULSE_CYCLES - 1))
		else $error("pulse time not loaded");
	a_ov_detect: assert property (@(posedge sys_clk) disable iff (srst)
		vbus_s2_q > ov_level |=> overvoltage_condition_q)
		else $error("overvoltage not flagged");
	a_zero_vector: assert property (@(posedge sys_clk) disable iff (srst)
		ov_detect |=> gate_low_q == `ALL_ON && gate_high_q == `ALL_OFF)
		else $error("zero vector not forced");
	a_zero_hold: assert property (@(posedge sys_clk) disable iff (srst)
		overvoltage_condition_q && !clr_s2_q |=> gate_low_q == `ALL_ON
			&& overvoltage_condition_q)
		else $error("zero vector released early");
	a_no_shoot: assert property (@(posedge sys_clk) disable iff (srst)
		(gate_high_q & gate_low_q) == `ALL_OFF)
		else $error("leg shoot through");
	a_pol_bit: assert property (@(posedge sys_clk) disable iff (srst)
		state_q == ST_REV && tmr_end && !guard_d
		|=> pol_q[$past(phase_q)] == ($past(fwd_peak_q) > $past(peak)))
		else $error("polarity bit wrong");
	a_done_flag: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(sector_done_q) |-> state_q == ST_DONE
			&& sector_q == polarity_to_sector(pol_q))
		else $error("done without sector");
	a_three_pairs: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(state_q == ST_DONE) |-> $past(phase_q) == `PHASE_IDX_W'(2))
		else $error("done before three pairs");
	c_sense_done: cover property (@(posedge sys_clk) $rose(sector_done_q));
	c_ov_trip: cover property (@(posedge sys_clk) $rose(overvoltage_condition_q));
	c_ov_release: cover property (@(posedge sys_clk)
		$fell(overvoltage_condition_q));
	c_ov_in_sense: cover property (@(posedge sys_clk) sensing_q && ov_detect);
endmodule

/* File: test/winding_model.sv */
// Half-bridge and motor winding model giving phase current samples
`timescale 1ns/1ps
`include "rotor_guard_defines.svh"
module winding_model
(
	input  wire logic                sys_clk,
	input  wire logic [`PHASES-1:0]  gate_high_q,
	input  wire logic [`PHASES-1:0]  gate_low_q,
	input  wire logic [`PHASES-1:0]  pol,
	output logic      [`ADC_W-1:0]   phase_current,
	output logic                     current_valid
);
	int         cnt;
	int         slope;
	int         v;
	logic [5:0] last;
	initial
	begin
		cnt = 0;
		last = 6'h00;
		phase_current = 12'h000;
		current_valid = 1'b0;
	end
	// Current rises faster when the field adds to the magnet
	always @(negedge sys_clk)
	begin
		if ({gate_high_q, gate_low_q} != last)
			cnt = 0;
		else
			cnt = cnt + 1;
		last = {gate_high_q, gate_low_q};
		slope = 0;
		for (int p = 0; p < 3; p++)
		begin
			if (gate_high_q == (3'h1 << p))
				slope = pol[p] ? 3 : 2;
			else if (gate_low_q == (3'h1 << p) && gate_high_q == (3'h7 ^ (3'h1 << p)))
				slope = pol[p] ? 2 : 3;
		end
		v = (cnt / 4) * slope;
		if (v > 4095)
			v = 4095;
		current_valid <= (slope != 0);
		// No pulse: sample stream is meaningless, so it keeps changing
		phase_current <= (slope != 0) ? v[`ADC_W-1:0] : ~phase_current;
	end
endmodule

/* File: test/tb.sv */
// Self-checking bench for rotor position finder and overvoltage guard
`timescale 1ns/1ps
`include "rotor_guard_defines.svh"
module tb;
	import rotor_guard_pkg::*;
	logic                 sys_clk, srst, sense_start, current_valid;
	logic                 ov_clear, fault_active, overvoltage_condition_q;
	logic                 sector_done_q, sensing_q;
	logic [`ADC_W-1:0]    phase_current, bus_voltage, ov_level;
	logic [`PHASES-1:0]   pwm_high_in, pwm_low_in, gate_high_q, gate_low_q, pol;
	logic [`SECTOR_W-1:0] sector_q;
	logic [5:0]           cur, e;
	logic [2:0]           f;
	logic [5:0]           pat_q[$];
	int                   len_q[$];
	int                   sec_of[8] = '{0, 1, 3, 2, 5, 6, 4, 0};
	int                   mismatches, n_checks, run, rec, i, p;
	rotor_position_and_bus_ov_guard uut
	(
		.sys_clk(sys_clk), .srst(srst), .sense_start(sense_start),
		.phase_current(phase_current), .current_valid(current_valid),
		.bus_voltage(bus_voltage), .ov_level(ov_level), .ov_clear(ov_clear),
		.pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in),
		.fault_active(fault_active), .gate_high_q(gate_high_q),
		.gate_low_q(gate_low_q),
		.overvoltage_condition_q(overvoltage_condition_q),
		.sector_q(sector_q), .sector_done_q(sector_done_q),
		.sensing_q(sensing_q)
	);
	winding_model motor
	(
		.sys_clk(sys_clk), .gate_high_q(gate_high_q), .gate_low_q(gate_low_q),
		.pol(pol), .phase_current(phase_current), .current_valid(current_valid)
	);
	always #4 sys_clk = ~sys_clk;
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****************************************
	// Gate monitor: records each non-zero pattern while rec is set
	// ****************************************
	always @(negedge sys_clk)
	begin
		if ((gate_high_q & gate_low_q) !== 3'h0)
			chk("shoot_through", 16'h0000, gate_high_q & gate_low_q);
		if ({gate_high_q, gate_low_q} !== cur)
		begin
			if (rec != 0 && cur != 6'h00)
			begin
				pat_q.push_back(cur);
				len_q.push_back(run);
			end
			cur = {gate_high_q, gate_low_q};
			run = 1;
		end
		else
			run++;
	end
	initial
	begin
		repeat (99000) @(posedge sys_clk);
		mismatches++;
		$display("[ERR] watchdog expected finish seen hang");
		final_report();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		sys_clk = 0;
		srst = 1;
		sense_start = 0;
		bus_voltage = 12'h100;
		ov_level = 12'h800;
		ov_clear = 0;
		pwm_high_in = 3'h0;
		pwm_low_in = 3'h0;
		fault_active = 0;
		pol = 3'h0;
		rec = 0;
		run = 0;
		cur = 6'h00;
		mismatches = 0;
		n_checks = 0;
		void'($urandom(98229));
		cyc(8);
		srst = 0;
		cyc(1);
		chk("gates_reset", 16'h0000, {gate_high_q, gate_low_q});
		chk("flags_reset", 16'h0000, {overvoltage_condition_q,
			sector_done_q, sensing_q, sector_q});
		repeat (4)
		begin
			f = 3'($urandom_range(7));
			pwm_high_in = f;
			pwm_low_in = ~f;
			cyc(5);
			chk("pwm_gates", {pwm_high_in, pwm_low_in},
				{gate_high_q, gate_low_q});
		end
		fault_active = 1;
		cyc(5);
		chk("fault_gates", 16'h0000, {gate_high_q, gate_low_q});
		bus_voltage = ov_level;
		cyc(6);
		chk("ov_at_level", 16'h0000, overvoltage_condition_q);
		bus_voltage = ov_level + 12'h001;
		cyc(4);
		chk("ov_flag", 16'h0001, overvoltage_condition_q);
		chk("zero_vector", 16'h0007, {gate_high_q, gate_low_q});
		ov_clear = 1;
		cyc(6);
		chk("ov_kept", 16'h0001, overvoltage_condition_q);
		chk("zero_kept", 16'h0007, {gate_high_q, gate_low_q});
		bus_voltage = ov_level;
		cyc(6);
		chk("ov_cleared", 16'h0000, overvoltage_condition_q);
		ov_clear = 0;
		fault_active = 0;
		cyc(5);
		chk("pwm_back", {pwm_high_in, pwm_low_in},
			{gate_high_q, gate_low_q});
		// Full sensing run with a restart request while busy
		pwm_high_in = 3'h0;
		pwm_low_in = 3'h0;
		// Let the PWM pattern leave the gates before recording starts
		cyc(2);
		p = $urandom_range(6, 1);
		pol = 3'(p);
		rec = 1;
		sense_start = 1;
		cyc(1000);
		chk("sensing", 16'h0001, sensing_q);
		sense_start = 0;
		cyc(7000);
		sense_start = 1;
		cyc(10);
		sense_start = 0;
		for (i = 0; i < 60000 && sector_done_q !== 1'b1; i++)
			cyc(1);
		if (sector_done_q !== 1'b1)
		begin
			chk("done_wait", 16'h0001, 16'h0000);
		end
		cyc(2);
		rec = 0;
		chk("sector", 16'(sec_of[p]), sector_q);
		chk("sense_idle", 16'h0000, sensing_q);
		chk("segments", 16'h0006, 16'(pat_q.size()));
		for (i = 0; i < 6 && i < pat_q.size(); i++)
		begin
			f = 3'h1 << (i / 2);
			e = (i % 2 == 0) ? {f, 3'h7 ^ f} : {3'h7 ^ f, f};
			chk("pattern", e, pat_q[i]);
			chk("pulse_len", 16'(`PULSE_CYCLES), 16'(len_q[i]));
		end
		// Overvoltage in mid-sensing aborts it
		sense_start = 1;
		cyc(200);
		bus_voltage = ov_level + 12'h001;
		cyc(4);
		chk("abort_zero", 16'h0007, {gate_high_q, gate_low_q});
		cyc(20);
		chk("abort_done", 16'h0000, sector_done_q);
		chk("abort_idle", 16'h0000, sensing_q);
		chk("abort_held", 16'h0007, {gate_high_q, gate_low_q});
		sense_start = 0;
		bus_voltage = ov_level;
		ov_clear = 1;
		cyc(6);
		ov_clear = 0;
		chk("abort_clear", 16'h0000, overvoltage_condition_q);
		final_report();
	end
endmodule
